// ### rtl/drds_defs.vh
// constants for the read data separator digital control block
`ifndef DRDS_DEFS_VH
`define DRDS_DEFS_VH
`define DRDS_CLK_MHZ 50
`define DRDS_REF_DIV_IDLE 2'h3
`define DRDS_FB_DIV_PHASE 2'h1
`define DRDS_FB_DIV_PFD 2'h3
`define DRDS_BW_LOW 2'h0
`define DRDS_BW_HIGH 2'h1
`define DRDS_BW_HIGH_READ 2'h2
`define DRDS_BW_HOLD 2'h3
`endif

// ### rtl/drds_sync2.v
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module drds_sync2 #(
    parameter WIDTH = 1
) (
    clock,
    rst,
    async_in,
    sync_out
);
    input wire clock;
    input wire rst;
    input wire [WIDTH-1:0] async_in;
    output reg [WIDTH-1:0] sync_out;

    reg [WIDTH-1:0] meta_reg;

    // the first stage feeds only the second stage
    always @(posedge clock) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ### rtl/drds_top.v
// read data separator control: source select, phase detector, dividers and retiming
`timescale 1ns/100ps
`include "drds_defs.vh"

// How it works
// RULE1: read low tracks data, high tracks reference
// RULE2: host supplies reference at 2f or 1.5f
// RULE3: read pulses active high, one per transition
// RULE4: bandwidth mode from select and read gate
// RULE5: hold low clears and parks phase detector
// RULE6: extra divider select low bypasses halving stage
// RULE7: test inject low feeds divider from test pin
// RULE8: force input low keeps phase-frequency mode
// RULE9: sync data changes on bit clock fall
// RULE10: bit clock rise marks valid data
// RULE11: oscillator output at divided oscillator rate
// RULE12: raise output follows detector raise command
// RULE13: lower output follows detector lower command
// RULE14: phase-only when reading, else phase-frequency
// RULE15: feedback divides two or four by mode
// RULE16: both pump commands high resets both
// RULE17: decode window formed on divided clock fall
// RULE18: mode inputs synchronised before taking effect
module drds_top (
    clock,
    rst,
    reference_osc_in,
    read_pulse_in,
    read_gate_n,
    bandwidth_select_n,
    hold_select_n,
    extra_divider_select,
    divider_test_inject_n,
    force_freq_detect_n,
    test_osc_in,
    sync_data_out,
    recovered_bit_clock_out,
    osc_freq_out,
    pump_raise_out,
    pump_lower_out,
    bandwidth_mode_out,
    phase_freq_mode_out
);
    input wire clock;
    input wire rst;
    input wire reference_osc_in;
    input wire read_pulse_in;
    input wire read_gate_n;
    input wire bandwidth_select_n;
    input wire hold_select_n;
    input wire extra_divider_select;
    input wire divider_test_inject_n;
    input wire force_freq_detect_n;
    input wire test_osc_in;
    output reg sync_data_out;
    output reg recovered_bit_clock_out;
    output reg osc_freq_out;
    output reg pump_raise_out;
    output reg pump_lower_out;
    output reg [1:0] bandwidth_mode_out;
    output reg phase_freq_mode_out;

    // every input other than clock and rst is asynchronous to clock; all nine pass two flops first
    wire [8:0] pins_sync;
    drds_sync2 #(
        .WIDTH(9)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({reference_osc_in, read_pulse_in, read_gate_n, bandwidth_select_n,
            hold_select_n, extra_divider_select, divider_test_inject_n,
            force_freq_detect_n, test_osc_in}),
        .sync_out(pins_sync)
    );

    wire ref_s = pins_sync[8];
    wire pulse_s = pins_sync[7];
    wire read_n_s = pins_sync[6];
    wire bw_n_s = pins_sync[5];
    wire hold_n_s = pins_sync[4];
    wire xdiv_s = pins_sync[3];
    wire test_n_s = pins_sync[2];
    wire force_n_s = pins_sync[1];
    wire tosc_s = pins_sync[0];

    // internal oscillator model: toggles every clock, stands in for the vco
    reg osc_reg;
    // pre-divider and feedback chain
    reg prediv_reg;
    reg [1:0] fb_cnt_reg;
    reg half_reg;
    reg half_d_reg;
    reg tosc_d_reg;
    reg ref_d_reg;
    reg pulse_d_reg;
    // mode latches, updated only on a divided clock fall
    reg reading_reg;
    reg pfd_reg;
    reg xdiv_reg;
    reg test_reg;
    reg hold_reg;
    reg bw_n_reg;
    // phase detector state
    reg up_reg;
    reg dn_reg;
    reg data_win_reg;

    wire osc_src = test_reg ? tosc_s : osc_reg; // see RULE7
    wire osc_prev = test_reg ? tosc_d_reg : ~osc_reg;
    wire osc_rise = osc_src & ~osc_prev;
    // pre-divider bypass or insertion decides the divider chain input edge
    wire chain_tick = xdiv_reg ? (osc_rise & prediv_reg) : osc_rise; // see RULE6
    wire half_fall = half_d_reg & ~half_reg;
    wire ref_rise = ref_s & ~ref_d_reg;
    wire pulse_rise = pulse_s & ~pulse_d_reg; // see RULE3
    wire [1:0] fb_limit = pfd_reg ? `DRDS_FB_DIV_PFD : `DRDS_FB_DIV_PHASE; // see RULE15
    wire fb_tick = chain_tick & (fb_cnt_reg == fb_limit);
    // reference drives the detector when idle, data pulses while reading
    wire in_edge = reading_reg ? pulse_rise : ref_rise; // see RULE1
    // phase-only mode waits for a data pulse before comparing
    wire fb_edge = pfd_reg ? fb_tick : (fb_tick & (up_reg | data_win_reg)); // see RULE14
    reg up_next;
    reg dn_next;
    reg [1:0] bw_next;

    always @* begin
        up_next = up_reg | in_edge;
        dn_next = dn_reg | fb_edge;
        if (up_next & dn_next) begin
            up_next = 1'b0; // see RULE16
            dn_next = 1'b0;
        end
        if (hold_reg) begin
            up_next = 1'b0; // see RULE5
            dn_next = 1'b0;
        end
        if (hold_reg)
            bw_next = `DRDS_BW_HOLD;
        else if (bw_n_reg)
            bw_next = `DRDS_BW_LOW;
        else if (reading_reg)
            bw_next = `DRDS_BW_HIGH_READ;
        else
            bw_next = `DRDS_BW_HIGH; // see RULE4
    end

    always @(posedge clock) begin
        if (rst) begin
            osc_reg <= 1'b0;
            prediv_reg <= 1'b0;
            fb_cnt_reg <= 2'h0;
            half_reg <= 1'b0;
            half_d_reg <= 1'b0;
            tosc_d_reg <= 1'b0;
            ref_d_reg <= 1'b0;
            pulse_d_reg <= 1'b0;
            reading_reg <= 1'b0;
            pfd_reg <= 1'b1;
            xdiv_reg <= 1'b1;
            test_reg <= 1'b0;
            hold_reg <= 1'b0;
            bw_n_reg <= 1'b1;
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            data_win_reg <= 1'b0;
            sync_data_out <= 1'b0;
            recovered_bit_clock_out <= 1'b0;
            osc_freq_out <= 1'b0;
            pump_raise_out <= 1'b0;
            pump_lower_out <= 1'b0;
            bandwidth_mode_out <= `DRDS_BW_LOW;
            phase_freq_mode_out <= 1'b1;
        end else begin
            osc_reg <= ~osc_reg;
            tosc_d_reg <= tosc_s;
            ref_d_reg <= ref_s;
            pulse_d_reg <= pulse_s;
            if (osc_rise)
                prediv_reg <= ~prediv_reg;
            if (chain_tick) begin
                half_reg <= ~half_reg;
                fb_cnt_reg <= (fb_cnt_reg == fb_limit) ? 2'h0 : fb_cnt_reg + 2'h1;
                osc_freq_out <= ~osc_freq_out; // see RULE11
            end
            half_d_reg <= half_reg;
            // mode changes wait for a divided clock fall so no pulse is cut short
            if (half_fall) begin
                reading_reg <= ~read_n_s; // see RULE18
                pfd_reg <= read_n_s | ~force_n_s; // see RULE8
                xdiv_reg <= xdiv_s;
                test_reg <= ~test_n_s;
                hold_reg <= ~hold_n_s;
                bw_n_reg <= bw_n_s;
            end
            // a data pulse opens the window until the next divided clock fall
            if (pulse_rise & reading_reg & ~hold_reg)
                data_win_reg <= 1'b1;
            else if (half_fall)
                data_win_reg <= 1'b0;
            up_reg <= up_next;
            dn_reg <= dn_next;
            pump_raise_out <= up_next; // see RULE12
            pump_lower_out <= dn_next; // see RULE13
            bandwidth_mode_out <= bw_next;
            phase_freq_mode_out <= pfd_reg;
            // bit clock follows the divided clock, data retimed on its fall
            recovered_bit_clock_out <= half_reg; // see RULE10
            if (half_fall)
                sync_data_out <= data_win_reg | (pulse_rise & reading_reg); // see RULE17 RULE9
        end
    end
endmodule

// ### verification/drds_checker.sv
// concurrent checks on the separator control ports
`timescale 1ns/100ps
`include "drds_defs.vh"
module drds_checker (
    input wire clock,
    input wire rst,
    input wire read_gate_n,
    input wire bandwidth_select_n,
    input wire hold_select_n,
    input wire force_freq_detect_n,
    input wire sync_data_out,
    input wire recovered_bit_clock_out,
    input wire pump_raise_out,
    input wire pump_lower_out,
    input wire [1:0] bandwidth_mode_out,
    input wire phase_freq_mode_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // steady-input counters: fifteen cycles cover two sync flops, the slowest internal-oscillator
    // divided-clock fall and the output register, which a short repeat does not
    reg [3:0] hold_cnt = 4'h0;
    reg [3:0] force_cnt = 4'h0;
    reg [3:0] read_cnt = 4'h0;
    reg [3:0] idle_cnt = 4'h0;
    reg [3:0] bwi_cnt = 4'h0;
    reg [3:0] bwr_cnt = 4'h0;
    always @(posedge clock) begin
        hold_cnt <= (rst || hold_select_n) ? 4'h0 : (hold_cnt == 4'hF) ? 4'hF : hold_cnt + 4'h1;
        force_cnt <= (rst || force_freq_detect_n) ? 4'h0 :
            (force_cnt == 4'hF) ? 4'hF : force_cnt + 4'h1;
        read_cnt <= (rst || read_gate_n || !force_freq_detect_n) ? 4'h0 :
            (read_cnt == 4'hF) ? 4'hF : read_cnt + 4'h1;
        idle_cnt <= (rst || !read_gate_n) ? 4'h0 : (idle_cnt == 4'hF) ? 4'hF : idle_cnt + 4'h1;
        bwi_cnt <= (rst || !read_gate_n || bandwidth_select_n || !hold_select_n) ? 4'h0 :
            (bwi_cnt == 4'hF) ? 4'hF : bwi_cnt + 4'h1;
        bwr_cnt <= (rst || read_gate_n || bandwidth_select_n || !hold_select_n) ? 4'h0 :
            (bwr_cnt == 4'hF) ? 4'hF : bwr_cnt + 4'h1;
    end
    one_pump_only_a: assert property (!(pump_raise_out && pump_lower_out))
        else $error("pumps both high");
    hold_parks_pumps_a: assert property (hold_cnt == 4'hF |-> !pump_raise_out && !pump_lower_out)
        else $error("pump active in hold");
    data_moves_low_a: assert property ($changed(sync_data_out) |-> !recovered_bit_clock_out)
        else $error("data moved with bit clock high");
    force_freq_mode_a: assert property (force_cnt == 4'hF |-> phase_freq_mode_out)
        else $error("forced mode lost");
    read_phase_only_a: assert property (read_cnt == 4'hF |-> !phase_freq_mode_out)
        else $error("read not phase only");
    idle_freq_mode_a: assert property (idle_cnt == 4'hF |-> phase_freq_mode_out)
        else $error("idle not phase frequency");
    bw_high_idle_a: assert property (bwi_cnt == 4'hF
        |-> bandwidth_mode_out == `DRDS_BW_HIGH) else $error("idle bandwidth wrong");
    bw_high_read_a: assert property (bwr_cnt == 4'hF
        |-> bandwidth_mode_out == `DRDS_BW_HIGH_READ) else $error("read bandwidth wrong");
    cover property (pump_raise_out);
    cover property (pump_lower_out);
    cover property ($rose(recovered_bit_clock_out) && sync_data_out);
endmodule

// ### verification/drds_channel_model.sv
// read channel pulse source and downstream decoder model
`timescale 1ns/100ps
module drds_channel_model (
    input wire clock,
    input wire pulse_enable,
    input wire recovered_bit_clock_out,
    input wire sync_data_out,
    output reg reference_osc_in,
    output reg read_pulse_in,
    output reg [15:0] ones_seen
);
    reg [2:0] phase_reg = 3'h0;
    reg clk_prev = 1'b0;
    initial begin
        reference_osc_in = 1'b0;
        read_pulse_in = 1'b0;
        ones_seen = 16'h0;
    end
    always @(posedge clock) begin
        phase_reg <= phase_reg + 3'h1;
        reference_osc_in <= phase_reg[1];
        // one-cycle pulse every eight clocks keeps edges well apart
        read_pulse_in <= pulse_enable && (phase_reg == 3'h0);
        clk_prev <= recovered_bit_clock_out;
        if (recovered_bit_clock_out && !clk_prev && sync_data_out) begin
            ones_seen <= ones_seen + 16'h1;
        end
    end
endmodule

// ### verification/disk_read_data_separator_test.sv
// self-checking bench for the read data separator control
`timescale 1ns/100ps
`include "drds_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module disk_read_data_separator_test;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg read_gate_n = 1'b1;
    reg bandwidth_select_n = 1'b1;
    reg hold_select_n = 1'b1;
    reg extra_divider_select = 1'b0;
    reg divider_test_inject_n = 1'b1;
    reg force_freq_detect_n = 1'b1;
    reg test_osc_in = 1'b0;
    reg pulse_enable = 1'b0;
    wire reference_osc_in, read_pulse_in, sync_data_out, recovered_bit_clock_out;
    wire osc_freq_out, pump_raise_out, pump_lower_out, phase_freq_mode_out;
    wire [1:0] bandwidth_mode_out;
    wire [15:0] ones_seen;
    int num_errors = 0;
    int comparisons = 0;
    int n0, n1, n;
    reg [2:0] tosc_div = 3'h0;
    always #10 clock = ~clock;
    // test oscillator runs free at one rise per eight clocks; a still one would freeze
    // the divided clock and with it every later mode change
    always @(posedge clock) begin
        tosc_div <= tosc_div + 3'h1;
        test_osc_in <= tosc_div[2];
    end
    drds_top dut (.*);
    drds_channel_model partner (.*);
    // m is {read, bandwidth, hold, test inject, force, extra divider}
    task set_mode(input [5:0] m);
        @(posedge clock);
        {read_gate_n, bandwidth_select_n, hold_select_n, divider_test_inject_n,
            force_freq_detect_n, extra_divider_select} <= m;
        repeat (16) @(posedge clock);
        #1;
    endtask
    // counts osc toggles (sel 0) or cycles with a pump high (sel 1) over 64 cycles
    task count_out(input sel, output int c);
        reg p;
        c = 0;
        p = osc_freq_out;
        repeat (64) begin
            @(posedge clock);
            #1;
            if (sel ? (pump_raise_out || pump_lower_out) : (osc_freq_out !== p)) c++;
            p = osc_freq_out;
        end
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        set_mode(6'h3E);
        `CHK("pf_idle", 1'b1, phase_freq_mode_out);
        `CHK("bw_low", `DRDS_BW_LOW, bandwidth_mode_out);
        set_mode(6'h2E);
        `CHK("bw_idle_high", `DRDS_BW_HIGH, bandwidth_mode_out);
        set_mode(6'h3E);
        count_out(1'b0, n0);
        `CHK("osc_runs", 1'b1, n0 > 8);
        set_mode(6'h3F);
        count_out(1'b0, n1);
        `CHK("osc_halved", 1'b1, n1 > 4 && n0 >= 2 * n1 - 2 && n0 <= 2 * n1 + 2);
        set_mode(6'h3A);
        count_out(1'b0, n);
        `CHK("inject_rate", 8, n);
        $display("divider tests done");
        @(posedge clock);
        pulse_enable <= 1'b1;
        set_mode(6'h1E);
        count_out(1'b1, n);
        `CHK("pf_read", 1'b0, phase_freq_mode_out);
        `CHK("pumps_active", 1'b1, n > 0);
        `CHK("ones_decoded", 1'b1, ones_seen > 0);
        set_mode(6'h0E);
        `CHK("bw_read", `DRDS_BW_HIGH_READ, bandwidth_mode_out);
        set_mode(6'h1C);
        `CHK("pf_forced", 1'b1, phase_freq_mode_out);
        set_mode(6'h16);
        count_out(1'b1, n);
        `CHK("pumps_hold", 0, n);
        $display("read tests done");
        complete_run;
    end
    initial begin
        #200000;
        num_errors++;
        complete_run;
    end
endmodule
bind drds_top drds_checker chk (.*);
